// >>> hdl/ars_pkg.sv
// Constants and state type shared by the reset and power-down sequencer.
package ars_pkg;

    // Clock rate of clk_sys.
    localparam int CLK_FREQ_MHZ = 200;

    // Initialization length in sys_clk_in periods.
    localparam int INIT_PERIODS = 1024;
    localparam logic [9:0] INIT_LAST = 10'(INIT_PERIODS - 1);

    // Shortest reset low pulse that is recognized, in ns, and as clk_sys cycles (rounded up).
    localparam int RST_MIN_NS = 40;
    localparam logic [3:0] RST_MIN_CYC = 4'((RST_MIN_NS * CLK_FREQ_MHZ + 999) / 1000);

    // Reset low time that leads to power-down, in sys_clk_in cycles.
    localparam int PD_PERIODS = 65536;

    // Clock activity detection: edges needed, and longest gap between edges in clk_sys cycles.
    localparam logic [2:0] CLK_DET_EDGES = 3'h4;
    localparam logic [7:0] CLK_GAP_CYC = 8'h40;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_WAIT_POR,
        ST_WAIT_CLK,
        ST_INIT,
        ST_RUN,
        ST_HOLD,
        ST_PD
    } ars_state_e;

endpackage

// >>> hdl/ars_clk_detect.sv
// Edge and activity detector for the system clock input pin.
`timescale 1ns/1ps

module ars_clk_detect (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Sampled clock pin
    input wire logic sys_clk_in,
    // Detection results
    output logic sys_edge,
    output logic clk_act
);

    logic prev_r;
    logic prev_nxt;
    logic [7:0] gap_r;
    logic [7:0] gap_nxt;
    logic [2:0] edges_r;
    logic [2:0] edges_nxt;
    logic act_r;
    logic act_nxt;
    logic rise;

    ////////////////////////////////////////////////////////////////////////////////

    // The pin must toggle slower than half of clk_sys for the edge detect to be reliable.
    always_comb begin
        rise = sys_clk_in & ~prev_r;
        prev_nxt = sys_clk_in;
        gap_nxt = gap_r;
        edges_nxt = edges_r;
        act_nxt = act_r;
        if (rise) begin
            gap_nxt = 8'h00;
            if (edges_r != ars_pkg::CLK_DET_EDGES) begin
                edges_nxt = edges_r + 3'h1;
            end
            if (edges_r == ars_pkg::CLK_DET_EDGES - 3'h1) begin
                act_nxt = 1'b1;
            end
        end else if (gap_r == ars_pkg::CLK_GAP_CYC) begin
            edges_nxt = 3'h0;
            act_nxt = 1'b0;
        end else begin
            gap_nxt = gap_r + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prev_r <= 1'b0;
            gap_r <= 8'h00;
            edges_r <= 3'h0;
            act_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            gap_r <= gap_nxt;
            edges_r <= edges_nxt;
            act_r <= act_nxt;
        end
    end

    assign sys_edge = rise;
    assign clk_act = act_r;

endmodule // ars_clk_detect

// >>> hdl/ars_sequencer.sv
// Reset, initialization and power-down sequencer for the converter's digital section.
// What this block does
// - After power-on reset releases, stay idle until the system clock input is seen active.
// - Each initialization lasts exactly 1024 system clock input periods.
// - Data outputs are driven low while initialization runs.
// - When initialization ends, data outputs are released for normal operation.
// - The active-low reset pin is honoured while the clock runs; its rise starts a new init.
// - Reset held low for 65,536 system clock input cycles enters power-down.
// - In power-down the internal clocks stop and all data outputs stay low.
// - Leaving power-down needs only reset high; a full init then runs once the clock is seen active.
`timescale 1ns/1ps

module ars_sequencer #(
    parameter int PD_PERIODS = ars_pkg::PD_PERIODS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Power-on reset from the supply monitor, asynchronous, low while supplies are low
    input wire logic por_n_async,
    // System controller pins
    input wire logic sys_clk_in,
    input wire logic rst_n_pin,
    // Converter core data
    input wire logic [3:0] conv_data_in,
    // Data output pins
    output logic [3:0] data_out,
    // Status and core control
    output logic out_enable,
    output logic init_busy,
    output logic power_down,
    output logic core_clk_en
);

    localparam logic [16:0] PD_LAST = 17'(PD_PERIODS - 1);

    logic por_meta_r;
    logic por_sync_r;
    logic sys_edge;
    logic clk_act;
    logic rst_low_ok;
    ars_pkg::ars_state_e st_r;
    ars_pkg::ars_state_e st_nxt;
    logic [9:0] init_cnt_r;
    logic [9:0] init_cnt_nxt;
    logic [16:0] pd_cnt_r;
    logic [16:0] pd_cnt_nxt;
    logic [3:0] lowf_r;
    logic [3:0] lowf_nxt;
    logic [3:0] data_nxt;
    logic out_en_nxt;
    logic busy_nxt;
    logic pd_nxt;
    logic clk_en_nxt;

    ////////////////////////////////////////////////////////////////////////////////

    // The first stage is read only by the second.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            por_meta_r <= 1'b0;
            por_sync_r <= 1'b0;
        end else begin
            por_meta_r <= por_n_async;
            por_sync_r <= por_meta_r;
        end
    end

    ars_clk_detect u_clk_detect (
        .clk_sys(clk_sys),
        .rst(rst),
        .sys_clk_in(sys_clk_in),
        .sys_edge(sys_edge),
        .clk_act(clk_act)
    );

    ////////////////////////////////////////////////////////////////////////////////

    // Shorter low pulses are treated as glitches, so a controller must respect the minimum width.
    always_comb begin
        lowf_nxt = 4'h0;
        if (!rst_n_pin) begin
            lowf_nxt = (lowf_r == ars_pkg::RST_MIN_CYC) ? lowf_r : lowf_r + 4'h1;
        end
        rst_low_ok = (lowf_r == ars_pkg::RST_MIN_CYC) && !rst_n_pin;
    end

    always_comb begin
        st_nxt = st_r;
        init_cnt_nxt = init_cnt_r;
        pd_cnt_nxt = pd_cnt_r;
        unique case (st_r)
            ars_pkg::ST_WAIT_POR: begin
                st_nxt = ars_pkg::ST_WAIT_CLK;
            end
            ars_pkg::ST_WAIT_CLK: begin
                if (rst_low_ok) begin
                    st_nxt = ars_pkg::ST_HOLD;
                    pd_cnt_nxt = 17'h00000;
                end else if (clk_act) begin
                    st_nxt = ars_pkg::ST_INIT;
                    init_cnt_nxt = 10'h000;
                end
            end
            ars_pkg::ST_INIT: begin
                if (rst_low_ok) begin
                    st_nxt = ars_pkg::ST_HOLD;
                    pd_cnt_nxt = 17'h00000;
                end else if (sys_edge) begin
                    if (init_cnt_r == ars_pkg::INIT_LAST) begin
                        st_nxt = ars_pkg::ST_RUN;
                    end else begin
                        init_cnt_nxt = init_cnt_r + 10'h001;
                    end
                end
            end
            ars_pkg::ST_RUN: begin
                if (rst_low_ok) begin
                    st_nxt = ars_pkg::ST_HOLD;
                    pd_cnt_nxt = 17'h00000;
                end
            end
            ars_pkg::ST_HOLD: begin
                if (rst_n_pin) begin
                    init_cnt_nxt = 10'h000;
                    st_nxt = clk_act ? ars_pkg::ST_INIT : ars_pkg::ST_WAIT_CLK;
                end else if (sys_edge) begin
                    if (pd_cnt_r == PD_LAST) begin
                        st_nxt = ars_pkg::ST_PD;
                    end else begin
                        pd_cnt_nxt = pd_cnt_r + 17'h00001;
                    end
                end
            end
            ars_pkg::ST_PD: begin
                // The clock may be gone here; init only starts once it is seen again.
                if (rst_n_pin) begin
                    st_nxt = ars_pkg::ST_WAIT_CLK;
                end
            end
            default: begin
                st_nxt = ars_pkg::ST_WAIT_POR;
            end
        endcase
        if (!por_sync_r) begin
            st_nxt = ars_pkg::ST_WAIT_POR;
        end
    end

    // Outputs are computed from the next state so that they change with it.
    always_comb begin
        out_en_nxt = (st_nxt == ars_pkg::ST_RUN);
        data_nxt = out_en_nxt ? conv_data_in : 4'h0;
        busy_nxt = (st_nxt == ars_pkg::ST_INIT);
        pd_nxt = (st_nxt == ars_pkg::ST_PD);
        clk_en_nxt = !pd_nxt;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= ars_pkg::ST_WAIT_POR;
            init_cnt_r <= 10'h000;
            pd_cnt_r <= 17'h00000;
            lowf_r <= 4'h0;
            data_out <= 4'h0;
            out_enable <= 1'b0;
            init_busy <= 1'b0;
            power_down <= 1'b0;
            core_clk_en <= 1'b1;
        end else begin
            st_r <= st_nxt;
            init_cnt_r <= init_cnt_nxt;
            pd_cnt_r <= pd_cnt_nxt;
            lowf_r <= lowf_nxt;
            data_out <= data_nxt;
            out_enable <= out_en_nxt;
            init_busy <= busy_nxt;
            power_down <= pd_nxt;
            core_clk_en <= clk_en_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Counts clock input edges seen during one initialization.
    logic [10:0] hlp_edges_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hlp_edges_r <= 11'h000;
        end else if (st_r != ars_pkg::ST_INIT) begin
            hlp_edges_r <= 11'h000;
        end else if (sys_edge) begin
            hlp_edges_r <= hlp_edges_r + 11'h001;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_idle_no_clock: assert property ((st_r == ars_pkg::ST_WAIT_CLK) && !clk_act |=> !init_busy)
        else $error("Initialization started without an active clock.");
    a_init_exact_len: assert property ($rose(out_enable) |-> hlp_edges_r == 11'h400)
        else $error("Initialization did not last 1024 clock periods.");
    a_data_low_init: assert property (init_busy |-> data_out == 4'h0)
        else $error("Data outputs not low during initialization.");
    a_release_after_init: assert property ($rose(out_enable) |-> $past(init_busy))
        else $error("Outputs released without a completed initialization.");
    a_reset_rise_init: assert property (
        (st_r == ars_pkg::ST_HOLD) && rst_n_pin && clk_act |=> init_busy && !out_enable)
        else $error("Reset release did not start initialization.");
    a_short_pulse_ignored: assert property (
        (st_r == ars_pkg::ST_RUN) && !rst_n_pin && (lowf_r < ars_pkg::RST_MIN_CYC)
        |=> out_enable)
        else $error("Too short reset pulse was acted upon.");
    a_pd_entry_count: assert property (
        $rose(power_down) |-> $past(pd_cnt_r) == PD_LAST && !$past(rst_n_pin))
        else $error("Power-down entered at the wrong count.");
    a_pd_outputs_low: assert property (power_down |-> data_out == 4'h0 && !core_clk_en)
        else $error("Power-down outputs not quiet.");
    a_pd_exit_init: assert property (power_down && rst_n_pin |=> !power_down && !out_enable
        ##1 !out_enable)
        else $error("Power-down exit skipped initialization.");
    a_por_holds: assert property (!por_sync_r |=> st_r == ars_pkg::ST_WAIT_POR && !out_enable)
        else $error("Power-on reset did not hold the sequencer.");

    c_init_done: cover property ($rose(out_enable));
    c_pd_entry: cover property ($rose(power_down));
    c_pd_exit: cover property ($fell(power_down));
    c_reset_in_init: cover property (init_busy ##1 (st_r == ars_pkg::ST_HOLD));

endmodule // ars_sequencer

// >>> verification/ars_ctrl_model.sv
// Behavioural model of the system controller that drives the clock and reset pins.
`timescale 1ns/1ps

module ars_ctrl_model #(
    parameter int HALF = 2
) (
    // Clock
    input wire logic clk_sys,
    // Commands from the bench
    input wire logic clk_on,
    input wire logic rst_hold,
    // Pins toward the device
    output logic sys_clk_in,
    output logic rst_n_pin
);
    int div;

    // The pin clock parks low when stopped, so no stray edge is left behind.
    always @(posedge clk_sys) begin
        if (!clk_on) begin
            sys_clk_in <= 1'b0;
            div <= 0;
        end else if (div == HALF - 1) begin
            sys_clk_in <= ~sys_clk_in;
            div <= 0;
        end else begin
            div <= div + 1;
        end
        // The bench decides how long the pin stays low; the model only forwards it.
        rst_n_pin <= ~rst_hold;
    end
endmodule // ars_ctrl_model

// >>> verification/ars_sequencer_tb.sv
// Self-checking testbench for the reset and power-down sequencer.
`timescale 1ns/1ps

module ars_sequencer_tb;
    localparam int PD_N = 16;
    localparam int T_LIMIT = 40000;
    logic clk_sys;
    logic rst;
    logic por_n_async;
    logic clk_on;
    logic rst_hold;
    logic sys_clk_in;
    logic rst_n_pin;
    logic [3:0] conv_data_in = 4'h0;
    logic [3:0] prev_d = 4'h0;
    logic [3:0] data_out;
    logic out_enable;
    logic init_busy;
    logic power_down;
    logic core_clk_en;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int t;

    ars_sequencer #(.PD_PERIODS(PD_N)) ars_sequencer_inst (
        .clk_sys(clk_sys), .rst(rst), .por_n_async(por_n_async), .sys_clk_in(sys_clk_in),
        .rst_n_pin(rst_n_pin), .conv_data_in(conv_data_in), .data_out(data_out),
        .out_enable(out_enable), .init_busy(init_busy), .power_down(power_down),
        .core_clk_en(core_clk_en)
    );

    ars_ctrl_model #(.HALF(2)) ars_ctrl_model_inst (
        .clk_sys(clk_sys), .clk_on(clk_on), .rst_hold(rst_hold),
        .sys_clk_in(sys_clk_in), .rst_n_pin(rst_n_pin)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic end_sim();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Data source, output reference and hang guard.
    always @(posedge clk_sys) begin
        conv_data_in <= conv_data_in + 4'h1;
        prev_d <= conv_data_in;
        cyc <= cyc + 1;
        if (cyc >= T_LIMIT) begin
            n_errors++;
            $display("mismatch timeout expected done seen running");
            end_sim();
        end
    end

    // Outputs are low unless enabled, and follow the core one cycle late when enabled.
    always @(negedge clk_sys) begin
        if (!rst) begin
            if (out_enable !== 1'b1) chk("data_out held low", 32'h0, 32'(data_out));
            else chk("data_out passes", 32'(prev_d), 32'(data_out));
        end
    end

    task automatic wait_hi(input int sel, input logic lvl, input int lim, output int took);
        logic v;
        took = 0;
        do begin
            @(negedge clk_sys);
            took++;
            case (sel)
                0: v = init_busy;
                1: v = out_enable;
                default: v = power_down;
            endcase
        end while (v !== lvl && took < lim);
    endtask

    // One initialization: 1024 pin periods of four system cycles each.
    // The first counted edge lands one to four cycles after entry, so 4093 to 4096 cycles.
    task automatic run_init();
        wait_hi(0, 1'b1, 100, t);
        chk("init_busy rises", 32'h1, 32'(init_busy));
        wait_hi(1, 1'b1, 5000, t);
        chk("init length in range", 32'h1, 32'(t >= 4093 && t <= 4096));
        chk("init_busy ends", 32'h0, 32'(init_busy));
    endtask

    task automatic t_power_on();
        rst <= 1'b0;
        repeat (50) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("idle while supply low", 32'h0, 32'(init_busy | out_enable));
        @(posedge clk_sys);
        por_n_async <= 1'b1;
        repeat (200) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("idle without pin clock", 32'h0, 32'(init_busy));
        @(posedge clk_sys);
        clk_on <= 1'b1;
        run_init();
    endtask

    task automatic t_ext_reset();
        @(posedge clk_sys);
        rst_hold <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rst_hold <= 1'b0;
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("short pulse ignored", 32'h1, 32'(out_enable));
        @(posedge clk_sys);
        rst_hold <= 1'b1;
        wait_hi(1, 1'b0, 14, t);
        chk("reset recognized", 32'h0, 32'(out_enable));
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("short hold no power-down", 32'h0, 32'(power_down));
        @(posedge clk_sys);
        rst_hold <= 1'b0;
        run_init();
    endtask

    task automatic t_power_down();
        @(posedge clk_sys);
        rst_hold <= 1'b1;
        wait_hi(2, 1'b1, 4 * PD_N + 30, t);
        chk("power_down entered", 32'h1, 32'(power_down));
        chk("core clock stopped", 32'h0, 32'(core_clk_en));
        @(posedge clk_sys);
        clk_on <= 1'b0;
        repeat (100) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("power_down holds", 32'h1, 32'(power_down));
        @(posedge clk_sys);
        clk_on <= 1'b1;
        repeat (40) @(posedge clk_sys);
        rst_hold <= 1'b0;
        wait_hi(2, 1'b0, 4, t);
        chk("power_down left", 32'h1, 32'(core_clk_en & ~power_down));
        run_init();
    endtask

    initial begin
        rst = 1'b1;
        por_n_async = 1'b0;
        clk_on = 1'b0;
        rst_hold = 1'b0;
        repeat (20) @(posedge clk_sys);
        t_power_on();
        t_ext_reset();
        t_power_down();
        end_sim();
    end
endmodule // ars_sequencer_tb
